// ### hw/fiw_pkg.sv
// Shared opcodes, field layout, timing counts and state types for the flash command slice
`default_nettype none
package fiw_pkg;
    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_RELEASE     = 8'hAB;
    localparam logic [7:0] OP_POWER_DOWN  = 8'hB9;
    localparam logic [7:0] OP_SET_PARAMS  = 8'hC0;
    localparam logic [7:0] OP_JEDEC_ID    = 8'h9F;
    localparam logic [7:0] OP_JEDEC_ID_Q  = 8'hAF;
    localparam logic [7:0] OP_MAKER_DEV   = 8'h90;
    localparam logic [7:0] OP_UNIQUE_ID   = 8'h4B;
    localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;
    localparam logic [2:0] ARGS_UNKNOWN   = 3'h7;

    // ************************************************************
    // Read parameter byte layout
    // ************************************************************
    localparam int         DRV_W        = 3;
    localparam int         DRV_POS      = 5;
    localparam int         WRAP_EN_POS  = 2;
    localparam int         WRAP_LEN_POS = 0;
    // Drive code k gives (k+1)/8 of full strength
    localparam logic [2:0] DRV_RESET    = 3'h3;
    localparam logic [2:0] DRV_FULL     = 3'h7;
    localparam logic [7:0] FILL_BYTE    = 8'hFF;
    // Parameter table: signature and header, 16 bytes at address 0
    localparam logic [127:0] PTABLE     = 128'h53464450_060100FF_00000000_00000000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         CLK_MHZ      = 200;
    localparam int         WAKE_NS      = 3000;
    localparam int         SCK_HALF_NS  = 40;
    localparam int         REC_W        = 10;
    localparam logic [REC_W-1:0] WAKE_CYC = REC_W'((WAKE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [REC_W-1:0] SYNC_MARGIN = 10'h008;
    localparam logic [REC_W-1:0] CS_GAP_CYC  = 10'h008;
    localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_NS * CLK_MHZ / 1000);

    typedef enum logic [1:0] {D_OPC = 2'b00, D_ARG = 2'b01, D_OUT = 2'b10, D_SKIP = 2'b11} fiw_dstate_t;
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b10, H_GAP = 2'b11} fiw_hstate_t;

    // Bytes that follow each opcode before data, or ARGS_UNKNOWN
    function automatic logic [2:0] arg_count(input logic [7:0] op);
        case (op)
            OP_RELEASE, OP_MAKER_DEV:      return 3'h3;
            OP_SET_PARAMS:                 return 3'h1;
            OP_UNIQUE_ID, OP_PARAM_TABLE:  return 3'h4;
            OP_JEDEC_ID, OP_JEDEC_ID_Q,
            OP_POWER_DOWN:                 return 3'h0;
            default:                       return ARGS_UNKNOWN;
        endcase
    endfunction: arg_count

    // Next read address, linear or wrapped inside the aligned burst
    function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic en, input logic [1:0] len);
        logic [7:0] m;
        logic [7:0] lo;
        m  = (8'h08 << len) - 8'h01;
        lo = a[7:0] + 8'h01;
        return en ? {a[23:8], (a[7:0] & ~m) | (lo & m)} : a + 24'h000001;
    endfunction: wrap_next
endpackage: fiw_pkg
`default_nettype wire

// ### hw/fiw_link_if.sv
// Serial link between flash host and flash device
`default_nettype none
interface fiw_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;
    // Released output floats high through the pull-up
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input sck, cs_n, si, output so, so_oe);
    modport host (output sck, cs_n, si, input so_line);
endinterface: fiw_link_if
`default_nettype wire

// ### hw/fiw_buf2.sv
// Two-entry valid/ready buffer
`default_nettype none
module fiw_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    logic [W-1:0] tail;
    logic         tail_v;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    // Ready comes from the tail flag, so a full buffer stalls the source
    assign in_ready = ~tail_v;

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            tail_v    <= 1'b0;
        end else if (pop & tail_v) begin
            out_data <= tail;
            tail_v   <= 1'b0;
        end else if (pop) begin
            out_valid <= push;
            out_data  <= in_data;
        end else if (push & out_valid) begin
            tail   <= in_data;
            tail_v <= 1'b1;
        end else if (push) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
        end
    end
endmodule: fiw_buf2
`default_nettype wire

// ### hw/fiw_dev.sv
// Flash device end: wake-up, read parameters and identification reads
`default_nettype none
// Behaviour
// R1 - Bare release opcode then deselect wakes device
// R2 - No instructions accepted during wake recovery
// R3 - Host keeps deselected through wake recovery
// R4 - Release opcode ignored while write busy
// R5 - Parameter command loads three drive bits
// R6 - Drive strength resets to half
// R7 - Wrap enable bit plus two length bits
// R8 - Codes 4..7 give 8,16,32,64 wrap
// R9 - Linear increment, or wrap inside page
// R10 - Wrap returns to burst start until deselect
// R11 - Wrap kept until cleared, powered down, reset
// R12 - Every read follows configured wrap
// R13 - Legacy ID after three dummies, MSB first
// R14 - Legacy ID repeats while selected
// R15 - Standard ID: maker, two code bytes, looping
// R16 - Address bit 0 picks maker/device order
// R17 - Unique ID: address, dummy, 16 bytes
// R18 - Unique ID repeats while clocked
// R19 - Table read: address, dummy, stream bytes
// R20 - Undefined table locations return filler
// R21 - Quad ID opcode shares standard framing
// R22 - Powered down: only release opcode recognised
// R23 - Reset restores all read parameters
// R24 - Drive encoding own; half code on reset
module fiw_dev #(
    parameter logic [7:0]   MAKER_CODE  = 8'hA5,     // Arbitrary value
    parameter logic [7:0]   DEVICE_CODE = 8'h3C,     // Arbitrary value
    parameter logic [15:0]  TYPE_CODE   = 16'h4B21,  // Arbitrary value
    parameter logic [127:0] UNIQUE_ID   = 128'h0123456789ABCDEF_FEDCBA9876543210  // Arbitrary value
) (
    input  wire logic                       CORE_CLK,
    input  wire logic                       SYS_RST,
    fiw_link_if.dev                         LINK,
    input  wire logic                       WRITE_IN_PROGRESS,
    output var  logic [fiw_pkg::DRV_W-1:0]  DRIVE_STRENGTH,
    output var  logic                       WRAP_ENABLE,
    output var  logic [1:0]                 WRAP_LENGTH,
    output var  logic                       POWER_DOWN
);
    import fiw_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0]       sck_s;
    logic [2:0]       cs_s;
    logic [1:0]       si_s;
    fiw_dstate_t      state;
    logic [2:0]       bcnt;
    logic [2:0]       argn;
    logic [7:0]       shreg;
    logic [7:0]       opc;
    logic [7:0]       cur_byte;
    logic [23:0]      addr;
    logic [1:0]       seq;
    logic             bare;
    logic             so_q;
    logic             oe_q;
    logic [REC_W-1:0] rec_cnt;

    // Stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sck_s <= 3'h0;
            cs_s  <= 3'h7;
            si_s  <= 2'h0;
        end else begin
            sck_s <= {sck_s[1:0], LINK.sck};
            cs_s  <= {cs_s[1:0], LINK.cs_n};
            si_s  <= {si_s[0], LINK.si};
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    wire         sck_rise   = sck_s[1] & ~sck_s[2];
    wire         sck_fall   = ~sck_s[1] & sck_s[2];
    wire         cs_high    = cs_s[1];
    wire         cs_rise    = cs_s[1] & ~cs_s[2];
    wire [7:0]   in_byte    = {shreg[6:0], si_s[1]};
    wire         byte_done  = sck_rise & ~cs_high & (bcnt == 3'h7);
    wire         in_out     = state == D_OUT;
    wire [2:0]   op_args    = arg_count(in_byte);
    wire         is_release = in_byte == OP_RELEASE;
    wire         recovering = rec_cnt != {REC_W{1'b0}};
    wire         op_jedec   = (in_byte == OP_JEDEC_ID) | (in_byte == OP_JEDEC_ID_Q);  // [R15] [R21]
    wire         op_refused = recovering                                   // [R2]
                            | (POWER_DOWN & ~is_release)                    // [R22]
                            | (is_release & WRITE_IN_PROGRESS)              // [R4]
                            | (op_args == ARGS_UNKNOWN);
    // Trailing dummy byte of the fast-read framing must not disturb the address
    wire         trail_dummy = (opc == OP_UNIQUE_ID) | (opc == OP_PARAM_TABLE);  // [R17] [R19]
    wire [23:0]  arg_addr   = (trail_dummy & (argn == 3'h1)) ? addr : {addr[15:0], in_byte};
    wire [23:0]  nxt_addr   = wrap_next(addr, WRAP_ENABLE, WRAP_LENGTH);  // [R9] [R10] [R12]
    wire         seq_jedec  = (opc == OP_JEDEC_ID) | (opc == OP_JEDEC_ID_Q);
    wire [1:0]   nxt_seq    = (seq_jedec & (seq == 2'h2)) ? 2'h0 : seq + 2'h1;  // [R15]
    wire [23:0]  src_addr   = in_out ? nxt_addr : arg_addr;
    wire [1:0]   src_seq    = in_out ? nxt_seq : 2'h0;
    wire [7:0]   src_op     = (state == D_OPC) ? in_byte : opc;
    wire [7:0]   src_byte;

    // Byte to shift out for a given command, address and sequence slot
    function automatic logic [7:0] byte_source(input logic [7:0] op, input logic [23:0] a, input logic [1:0] s);
        logic [7:0] b;
        b = FILL_BYTE;
        case (op)
            OP_RELEASE: begin
                b = DEVICE_CODE;  // [R13] [R14]
            end
            OP_JEDEC_ID, OP_JEDEC_ID_Q: begin
                b = (s == 2'h0) ? MAKER_CODE : (s == 2'h1) ? TYPE_CODE[15:8] : TYPE_CODE[7:0];  // [R15]
            end
            OP_MAKER_DEV: begin
                b = a[0] ? DEVICE_CODE : MAKER_CODE;  // [R16]
            end
            OP_UNIQUE_ID: begin
                b = UNIQUE_ID[{~a[3:0], 3'h0} +: 8];  // [R17] [R18]
            end
            OP_PARAM_TABLE: begin
                b = (a[23:4] == 20'h00000) ? PTABLE[{~a[3:0], 3'h0} +: 8] : FILL_BYTE;  // [R19] [R20]
            end
            default: begin
                b = FILL_BYTE;
            end
        endcase
        return b;
    endfunction: byte_source

    assign src_byte   = byte_source(src_op, src_addr, src_seq);
    assign LINK.so    = so_q;
    assign LINK.so_oe = oe_q;

    // ************************************************************
    // Command sequencer
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state          <= D_OPC;
            bcnt           <= 3'h0;
            argn           <= 3'h0;
            shreg          <= 8'h00;
            opc            <= 8'h00;
            cur_byte       <= 8'h00;
            addr           <= 24'h000000;
            seq            <= 2'h0;
            bare           <= 1'b0;
            so_q           <= 1'b0;
            oe_q           <= 1'b0;
            rec_cnt        <= {REC_W{1'b0}};
            POWER_DOWN     <= 1'b0;
            DRIVE_STRENGTH <= DRV_RESET;  // [R6] [R23] [R24]
            WRAP_ENABLE    <= 1'b0;       // [R23]
            WRAP_LENGTH    <= 2'h0;
        end else begin
            if (recovering) begin
                rec_cnt <= rec_cnt - 10'h001;  // [R2]
            end
            if (cs_high) begin
                state <= D_OPC;
                bcnt  <= 3'h0;
                bare  <= 1'b0;
                oe_q  <= 1'b0;
                if (cs_rise & bare & (opc == OP_RELEASE) & POWER_DOWN) begin
                    POWER_DOWN <= 1'b0;       // [R1]
                    rec_cnt    <= WAKE_CYC;   // [R2]
                end
                if (cs_rise & bare & (opc == OP_POWER_DOWN)) begin
                    POWER_DOWN  <= 1'b1;
                    WRAP_ENABLE <= 1'b0;      // [R11]
                end
            end else begin
                if (sck_rise) begin
                    bcnt  <= bcnt + 3'h1;
                    shreg <= in_byte;
                end
                if (sck_fall & in_out) begin
                    so_q <= cur_byte[~bcnt];  // [R13]
                    oe_q <= 1'b1;
                end
                if (byte_done) begin
                    bare <= 1'b0;
                    case (state)
                        D_OPC: begin
                            opc  <= in_byte;
                            argn <= op_args;
                            seq  <= 2'h0;
                            if (op_refused) begin
                                state <= D_SKIP;  // [R4] [R22]
                            end else if (op_args != 3'h0) begin
                                state <= D_ARG;
                                bare  <= 1'b1;
                            end else if (op_jedec) begin
                                state    <= D_OUT;
                                cur_byte <= src_byte;
                            end else begin
                                state <= D_SKIP;
                                bare  <= 1'b1;
                            end
                        end
                        D_ARG: begin
                            argn <= argn - 3'h1;
                            addr <= arg_addr;
                            if (opc == OP_SET_PARAMS) begin
                                DRIVE_STRENGTH <= in_byte[DRV_POS +: DRV_W];    // [R5]
                                WRAP_ENABLE    <= in_byte[WRAP_EN_POS];         // [R7] [R8] [R11]
                                WRAP_LENGTH    <= in_byte[WRAP_LEN_POS +: 2];   // [R7] [R8]
                                state          <= D_SKIP;
                            end else if (argn == 3'h1) begin
                                state    <= D_OUT;
                                cur_byte <= src_byte;
                            end
                        end
                        D_OUT: begin
                            addr     <= nxt_addr;   // [R10] [R12]
                            seq      <= nxt_seq;
                            cur_byte <= src_byte;   // [R14] [R18]
                        end
                        default: begin
                            state <= D_SKIP;
                        end
                    endcase
                end
            end
        end
    end
endmodule: fiw_dev
`default_nettype wire

// ### hw/fiw_host.sv
// Flash host end: frames one command per request and returns read bytes
`default_nettype none
module fiw_host (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    fiw_link_if.host         LINK,
    input  wire logic        CMD_VALID,
    output var  logic        CMD_READY,
    input  wire logic [7:0]  CMD_OPCODE,
    input  wire logic [2:0]  CMD_ARG_COUNT,
    input  wire logic [31:0] CMD_ARG,
    input  wire logic [7:0]  CMD_READ_COUNT,
    output var  logic        RX_VALID,
    input  wire logic        RX_READY,
    output var  logic [7:0]  RX_DATA
);
    import fiw_pkg::*;

    fiw_hstate_t             state;
    logic [1:0]              so_s;
    logic [3:0]              div;
    logic [39:0]             txsr;
    logic [5:0]              txbits;
    logic [7:0]              rxleft;
    logic [7:0]              rxsr;
    logic [2:0]              rbit;
    logic [fiw_pkg::REC_W-1:0] gap;
    logic                    wake;
    logic                    sck_q;
    logic                    cs_q;
    logic                    si_q;
    logic                    push;
    logic                    buf_ready;

    // ************************************************************
    // Bit timing
    // ************************************************************
    wire       half_done = div == (SCK_HALF_CYC - 4'h1);
    wire       rx_phase  = txbits == 6'h00;
    // A read byte starts only when the buffer can take it, so nothing is lost
    wire       stall     = rx_phase & (rbit == 3'h0) & ~buf_ready;
    wire [5:0] tx_left   = txbits - {5'h00, ~rx_phase};
    wire       last_bit  = (tx_left == 6'h00) & (rxleft == 8'h00);
    wire       is_wake   = (CMD_OPCODE == OP_RELEASE) & (CMD_ARG_COUNT == 3'h0) & (CMD_READ_COUNT == 8'h00);

    assign LINK.sck  = sck_q;
    assign LINK.cs_n = cs_q;
    assign LINK.si   = si_q;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            so_s <= 2'h3;
        end else begin
            so_s <= {so_s[0], LINK.so_line};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state     <= H_IDLE;
            div       <= 4'h0;
            txsr      <= 40'h0000000000;
            txbits    <= 6'h00;
            rxleft    <= 8'h00;
            rxsr      <= 8'h00;
            rbit      <= 3'h0;
            gap       <= {REC_W{1'b0}};
            wake      <= 1'b0;
            sck_q     <= 1'b0;
            cs_q      <= 1'b1;
            si_q      <= 1'b0;
            push      <= 1'b0;
            CMD_READY <= 1'b0;
        end else begin
            push <= 1'b0;
            case (state)
                H_IDLE: begin
                    CMD_READY <= ~(CMD_VALID & CMD_READY);
                    if (CMD_VALID & CMD_READY) begin
                        txsr   <= {CMD_OPCODE, CMD_ARG};
                        txbits <= {CMD_ARG_COUNT + 3'h1, 3'h0};
                        rxleft <= CMD_READ_COUNT;
                        rbit   <= 3'h0;
                        wake   <= is_wake;
                        cs_q   <= 1'b0;
                        si_q   <= CMD_OPCODE[7];
                        div    <= 4'h0;
                        state  <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (stall) begin
                        div <= 4'h0;
                    end else if (half_done) begin
                        div   <= 4'h0;
                        sck_q <= 1'b1;
                        state <= H_HIGH;
                        if (rx_phase) begin
                            rxsr <= {rxsr[6:0], so_s[1]};
                            rbit <= rbit + 3'h1;
                            if (rbit == 3'h7) begin
                                push   <= 1'b1;
                                rxleft <= rxleft - 8'h01;
                            end
                        end
                    end else begin
                        div <= div + 4'h1;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        div    <= 4'h0;
                        sck_q  <= 1'b0;
                        txbits <= tx_left;
                        txsr   <= {txsr[38:0], 1'b0};
                        if (last_bit) begin
                            cs_q  <= 1'b1;
                            gap   <= wake ? WAKE_CYC + SYNC_MARGIN : CS_GAP_CYC;  // [R3]
                            state <= H_GAP;
                        end else begin
                            si_q  <= (tx_left != 6'h00) & txsr[38];
                            state <= H_LOW;
                        end
                    end else begin
                        div <= div + 4'h1;
                    end
                end
                default: begin
                    if (gap == {REC_W{1'b0}}) begin
                        state <= H_IDLE;
                    end else begin
                        gap <= gap - 10'h001;  // [R3]
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Read data buffer
    // ************************************************************
    fiw_buf2 #(
        .W (8)
    ) u_rxbuf (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (rxsr),
        .out_valid (RX_VALID),
        .out_ready (RX_READY),
        .out_data  (RX_DATA)
    );
endmodule: fiw_host
`default_nettype wire

// ### testbench/fiw_link_monitor.sv
// Concurrent checks on the serial link between the host and device ends
`default_nettype none
module fiw_link_monitor (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    // ****
    // Link framing and bit timing
    // ****
    // The device finds sck edges by sampling, so short phases would be missed
    sequence sck_low_phase;
        !sck [*8];
    endsequence
    sequence sck_high_phase;
        sck [*8];
    endsequence
    a_sck_low_time: assert property ($fell(sck) |-> sck_low_phase) else $error("sck low phase short");
    a_sck_high_time: assert property ($rose(sck) |-> sck_high_phase) else $error("sck high phase short");
    a_select_setup: assert property ($fell(cs_n) |-> sck_low_phase) else $error("sck edge too soon");
    a_deselect_gap: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("deselect gap short");
    a_idle_sck_low: assert property (cs_n |-> !sck) else $error("sck toggles while deselected");
    a_si_held_high: assert property (sck && $past(sck) |-> $stable(si)) else $error("si moved while sck high");
    a_so_held_high: assert property ($changed(so) && so_oe && $past(so_oe) |-> !sck)
        else $error("so moved while sck high");
    a_so_released: assert property (cs_n [*6] |-> !so_oe) else $error("so still driven after deselect");
endmodule: fiw_link_monitor
`default_nettype wire

// ### testbench/flash_id_wake_readparam_cmds_tb_top.sv
// Bench: host and device ends on one link, driven through the host command port
`default_nettype none
module flash_id_wake_readparam_cmds_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fiw_pkg::*;
    localparam logic [7:0]   MK  = 8'hA5;    // Arbitrary value
    localparam logic [7:0]   DV  = 8'h3C;    // Arbitrary value
    localparam logic [15:0]  TY  = 16'h4B21; // Arbitrary value
    localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF; // Arbitrary value
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid = 1'b0, cmd_ready, rx_valid, rx_ready = 1'b1, busy = 1'b0, pwr, wrap_en;
    logic [7:0]  cmd_op = 8'h00, cmd_rc = 8'h00, rx_data;
    logic [2:0]  cmd_n = 3'h0, drv;
    logic [1:0]  wrap_len;
    logic [31:0] cmd_arg = 32'h00000000;
    logic [7:0]  rxq[$];
    int          bad_count = 0, compares = 0, stall = 0;
    always #2.5 core_clk = ~core_clk;
    fiw_link_if link ();
    fiw_dev #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .TYPE_CODE(TY), .UNIQUE_ID(UID)) u_fiw_dev (.CORE_CLK(core_clk),
        .SYS_RST(sys_rst), .LINK(link), .WRITE_IN_PROGRESS(busy), .DRIVE_STRENGTH(drv), .WRAP_ENABLE(wrap_en),
        .WRAP_LENGTH(wrap_len), .POWER_DOWN(pwr));
    fiw_host u_fiw_host (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK(link), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_OPCODE(cmd_op), .CMD_ARG_COUNT(cmd_n), .CMD_ARG(cmd_arg),
        .CMD_READ_COUNT(cmd_rc), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data));
    fiw_link_monitor u_fiw_link_monitor (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .sck(link.sck),
        .cs_n(link.cs_n), .si(link.si), .so(link.so), .so_oe(link.so_oe));
    // ****
    // Receive side: a stall count holds the reader off, and runs out before the t_uid_table read bytes arrive
    // ****
    always @(posedge core_clk) if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    always @(negedge core_clk) begin
        rx_ready <= (stall == 0);
        if (stall > 0) stall <= stall - 1;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask: check
    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask: tally_and_finish
    task automatic do_reset();
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask: do_reset
    task automatic wait_ready();
        for (int t = 0; t < 50000 && cmd_ready !== 1'b1; t++) @(negedge core_clk);
    endtask: wait_ready
    task automatic run(input logic [7:0] op, input logic [2:0] n, input logic [31:0] arg, input logic [7:0] rc);
        rxq.delete();
        wait_ready();
        cmd_op = op;
        cmd_n = n;
        cmd_arg = arg;
        cmd_rc = rc;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        wait_ready();
    endtask: run
    task automatic expect_bytes(input string what, input int n, input logic [143:0] exp);
        check({what, " count"}, 8'(rxq.size()), 8'(n));
        for (int i = 0; i < n; i++) check(what, rxq[i], exp[8*(n-1-i) +: 8]);
    endtask: expect_bytes
    task automatic t_defaults();
        check("drive", {5'h00, drv}, {5'h00, DRV_RESET});
        check("wrap", {5'h00, wrap_en, wrap_len}, 8'h00);
    endtask: t_defaults
    task automatic t_ident();
        run(OP_JEDEC_ID, 3'h0, 32'h00000000, 8'h06);
        expect_bytes("std id", 6, {MK, TY, MK, TY});
        run(OP_JEDEC_ID_Q, 3'h0, 32'h00000000, 8'h03);
        expect_bytes("quad id", 3, {MK, TY});
        run(OP_MAKER_DEV, 3'h3, 32'h00000000, 8'h03);
        expect_bytes("md id a0", 3, {MK, DV, MK});
        run(OP_MAKER_DEV, 3'h3, 32'h00000100, 8'h02);
        expect_bytes("md id a1", 2, {DV, MK});
        run(OP_RELEASE, 3'h3, 32'h00000000, 8'h03);
        expect_bytes("legacy id", 3, {DV, DV, DV});
    endtask: t_ident
    task automatic t_uid_table();
        stall = 600;
        run(OP_UNIQUE_ID, 3'h4, 32'h00000E00, 8'h12);
        expect_bytes("uid", 18, {UID[15:0], UID});
        run(OP_PARAM_TABLE, 3'h4, 32'h00000000, 8'h05);
        expect_bytes("table", 5, PTABLE[127:88]);
        run(OP_PARAM_TABLE, 3'h4, 32'h00010000, 8'h02);
        expect_bytes("table gap", 2, {FILL_BYTE, FILL_BYTE});
    endtask: t_uid_table
    task automatic t_wrap();
        run(OP_SET_PARAMS, 3'h1, 32'hE4000000, 8'h00);
        check("params a", {drv, 2'h0, wrap_en, wrap_len}, 8'hE4);
        run(OP_PARAM_TABLE, 3'h4, 32'h00000600, 8'h04);
        expect_bytes("wrap 8", 4, {PTABLE[79:64], PTABLE[127:112]});
        run(OP_SET_PARAMS, 3'h1, 32'h07000000, 8'h00);
        check("params b", {drv, 2'h0, wrap_en, wrap_len}, 8'h07);
        run(OP_PARAM_TABLE, 3'h4, 32'h00003E00, 8'h03);
        expect_bytes("wrap 64", 3, {FILL_BYTE, FILL_BYTE, PTABLE[127:120]});
    endtask: t_wrap
    task automatic t_power();
        run(OP_POWER_DOWN, 3'h0, 32'h00000000, 8'h00);
        check("down", {6'h00, pwr, wrap_en}, 8'h02);
        run(OP_JEDEC_ID, 3'h0, 32'h00000000, 8'h02);
        expect_bytes("id when down", 2, {FILL_BYTE, FILL_BYTE});
        busy = 1'b1;
        run(OP_RELEASE, 3'h0, 32'h00000000, 8'h00);
        check("busy wake", {7'h00, pwr}, 8'h01);
        busy = 1'b0;
        run(OP_RELEASE, 3'h0, 32'h00000000, 8'h00);
        check("wake", {7'h00, pwr}, 8'h00);
        run(OP_JEDEC_ID, 3'h0, 32'h00000000, 8'h03);
        expect_bytes("id after wake", 3, {MK, TY});
    endtask: t_power
    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        t_defaults();
        t_ident();
        t_uid_table();
        t_wrap();
        t_power();
        run(OP_SET_PARAMS, 3'h1, 32'hE6000000, 8'h00);
        do_reset();
        t_defaults();
        tally_and_finish();
    end
endmodule: flash_id_wake_readparam_cmds_tb_top
`default_nettype wire
